// ==== hw/papt_core.sv ====
`timescale 1ns/1ps
module papt_core #(
  parameter int NUM_ALARM = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // process sample tick from the sampling logic
  input wire logic sampleTick,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // demands and alarm pins
  output logic signed [15:0] heatPower,
  output logic signed [15:0] coolPower,
  output logic [NUM_ALARM-1:0] alarmOut
);
  import papt_pkg::*;

  // status and ack words and the alarm window hold four slots only
  if (NUM_ALARM < 1 || NUM_ALARM > 4) begin : gBadCount
    $error("NUM_ALARM must be 1..4 for the register map");
  end

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic int almIndex(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - PAPT_ALM_BASE;
    if (a < PAPT_ALM_BASE) begin
      return -1;
    end else if ({4'h0, rel[7:4]} >= 8'(NUM_ALARM)) begin
      return -1;
    end
    return int'(rel[7:4]);
  endfunction : almIndex

  function automatic logic [7:0] almField(input logic [7:0] a);
    return {4'h0, a[3:0]};
  endfunction : almField

  function automatic logic signed [15:0] clamp16(
    input logic signed [47:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi
  );
    if (v > 48'(hi)) begin
      return hi;
    end else if (v < 48'(lo)) begin
      return lo;
    end
    return v[15:0];
  endfunction : clamp16

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  logic signed [15:0] pv_q;
  logic signed [15:0] sp_q;
  logic signed [15:0] pwr_q;
  logic signed [15:0] offs_q;
  logic signed [15:0] dbnd_q;
  logic signed [15:0] hGain_q;
  logic signed [15:0] cGain_q;
  logic signed [15:0] hLo_q;
  logic signed [15:0] hHi_q;
  logic signed [15:0] cLo_q;
  logic signed [15:0] cHi_q;
  logic [NUM_ALARM-1:0] ack_q;
  logic [6:0] almCfg_q [NUM_ALARM];
  logic signed [15:0] almVal_q [NUM_ALARM];
  logic signed [15:0] almHys_q [NUM_ALARM];
  logic [NUM_ALARM-1:0] alm_q;
  logic [NUM_ALARM-1:0] alarmOut_q;

  // ------------------------------------------------------------
  // apb handshake and address check
  // ------------------------------------------------------------
  logic setupRd;
  logic accWr;
  logic addrOk;
  // -1 marks an address outside the alarm window
  int wIdx;
  assign setupRd = psel && !penable;
  assign accWr = psel && penable && pwrite;
  assign wIdx = almIndex(paddr);
  // every register answers at once, so no wait states are needed
  assign pready = 1'b1;

  always_comb begin
    addrOk = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      addrOk = 1'b0;
    end else if (paddr <= PAPT_ACK_OFF) begin
      addrOk = 1'b1;
    end else if (wIdx >= 0 && almField(paddr) <= PAPT_ALM_HYS) begin
      addrOk = 1'b1;
    end
  end
  // read-only words take writes silently; only holes are refused
  assign pslverr = psel && penable && !addrOk;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pv_q <= PAPT_ZERO;
      sp_q <= PAPT_ZERO;
      pwr_q <= PAPT_ZERO;
      offs_q <= PAPT_ZERO;
      dbnd_q <= PAPT_ZERO;
      hGain_q <= PAPT_GAIN_UNITY;
      cGain_q <= PAPT_GAIN_UNITY;
      hLo_q <= PAPT_ZERO;
      hHi_q <= PAPT_LIM_MAX;
      cLo_q <= PAPT_ZERO;
      cHi_q <= PAPT_LIM_MAX;
      ack_q <= '0;
      for (int i = 0; i < NUM_ALARM; i++) begin
        almCfg_q[i] <= 7'h00;
        almVal_q[i] <= PAPT_ZERO;
        almHys_q[i] <= PAPT_ZERO;
      end
    end else if (accWr && addrOk) begin
      if (paddr == PAPT_PV_OFF) begin
        pv_q <= pwdata[15:0];
      end else if (paddr == PAPT_SP_OFF) begin
        sp_q <= pwdata[15:0];
      end else if (paddr == PAPT_PWR_OFF) begin
        pwr_q <= pwdata[15:0];
      end else if (paddr == PAPT_OFFS_OFF) begin
        offs_q <= pwdata[15:0];
      end else if (paddr == PAPT_DBND_OFF) begin
        dbnd_q <= pwdata[15:0];
      end else if (paddr == PAPT_HGAIN_OFF) begin
        hGain_q <= pwdata[15:0];
      end else if (paddr == PAPT_CGAIN_OFF) begin
        cGain_q <= pwdata[15:0];
      end else if (paddr == PAPT_HLO_OFF) begin
        hLo_q <= pwdata[15:0];
      end else if (paddr == PAPT_HHI_OFF) begin
        hHi_q <= pwdata[15:0];
      end else if (paddr == PAPT_CLO_OFF) begin
        cLo_q <= pwdata[15:0];
      end else if (paddr == PAPT_CHI_OFF) begin
        cHi_q <= pwdata[15:0];
      end else if (paddr == PAPT_ACK_OFF) begin
        ack_q <= pwdata[NUM_ALARM-1:0];
      end else if (wIdx >= 0) begin
        if (almField(paddr) == PAPT_ALM_CFG) begin
          almCfg_q[wIdx] <= pwdata[6:0];
        end else if (almField(paddr) == PAPT_ALM_VAL) begin
          almVal_q[wIdx] <= pwdata[15:0];
        end else if (almField(paddr) == PAPT_ALM_HYS) begin
          almHys_q[wIdx] <= pwdata[15:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read path: data captured in the setup cycle
  // ------------------------------------------------------------
  logic [31:0] rd_d;
  logic [31:0] prdata_q;
  logic signed [15:0] heat_q;
  logic signed [15:0] cool_q;

  always_comb begin
    rd_d = 32'h0000_0000;
    if (paddr == PAPT_PV_OFF) begin
      rd_d = 32'(pv_q);
    end else if (paddr == PAPT_SP_OFF) begin
      rd_d = 32'(sp_q);
    end else if (paddr == PAPT_PWR_OFF) begin
      rd_d = 32'(pwr_q);
    end else if (paddr == PAPT_OFFS_OFF) begin
      rd_d = 32'(offs_q);
    end else if (paddr == PAPT_DBND_OFF) begin
      rd_d = 32'(dbnd_q);
    end else if (paddr == PAPT_HGAIN_OFF) begin
      rd_d = 32'(hGain_q);
    end else if (paddr == PAPT_CGAIN_OFF) begin
      rd_d = 32'(cGain_q);
    end else if (paddr == PAPT_HLO_OFF) begin
      rd_d = 32'(hLo_q);
    end else if (paddr == PAPT_HHI_OFF) begin
      rd_d = 32'(hHi_q);
    end else if (paddr == PAPT_CLO_OFF) begin
      rd_d = 32'(cLo_q);
    end else if (paddr == PAPT_CHI_OFF) begin
      rd_d = 32'(cHi_q);
    end else if (paddr == PAPT_HEAT_OFF) begin
      rd_d = 32'(heat_q);
    end else if (paddr == PAPT_COOL_OFF) begin
      rd_d = 32'(cool_q);
    end else if (paddr == PAPT_ASTAT_OFF) begin
      rd_d = 32'(alm_q);
    end else if (paddr == PAPT_ACK_OFF) begin
      rd_d = 32'(ack_q);
    end else if (wIdx >= 0) begin
      if (almField(paddr) == PAPT_ALM_CFG) begin
        rd_d = 32'(almCfg_q[wIdx]);
      end else if (almField(paddr) == PAPT_ALM_VAL) begin
        rd_d = 32'(almVal_q[wIdx]);
      end else if (almField(paddr) == PAPT_ALM_HYS) begin
        rd_d = 32'(almHys_q[wIdx]);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setupRd && !pwrite) begin
      // holes decode to zero here, so a refused read returns zero
      prdata_q <= rd_d;
    end
  end
  assign prdata = prdata_q;

  // ------------------------------------------------------------
  // power transfer
  // ------------------------------------------------------------
  // 48-bit products: full-scale power times a large gain overflows 32 bits
  logic signed [31:0] pTot;
  logic signed [31:0] halfDb;
  logic signed [47:0] heatRaw;
  logic signed [47:0] coolRaw;
  always_comb begin
    pTot = 32'(pwr_q) + 32'(offs_q);
    halfDb = 32'(dbnd_q) >>> 1;
    heatRaw = 48'sh0000_0000_0000;
    coolRaw = 48'sh0000_0000_0000;
    // negative deadband moves both thresholds past zero: overlap
    if (pTot > halfDb) begin
      heatRaw = 48'(pTot - halfDb) * 48'(hGain_q);
      heatRaw = heatRaw / 48'(PAPT_GAIN_UNITY);
    end
    if (pTot < -halfDb) begin
      coolRaw = 48'(-halfDb - pTot) * 48'(cGain_q);
      coolRaw = coolRaw / 48'(PAPT_GAIN_UNITY);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      heat_q <= PAPT_ZERO;
      cool_q <= PAPT_ZERO;
    end else if (sampleTick) begin
      heat_q <= clamp16(heatRaw, hLo_q, hHi_q);
      cool_q <= clamp16(coolRaw, cLo_q, cHi_q);
    end
  end
  assign heatPower = heat_q;
  assign coolPower = cool_q;

  // ------------------------------------------------------------
  // alarms
  // ------------------------------------------------------------
  logic signed [15:0] spSeen_q;
  logic spChange;
  // compared per sample, so several writes between samples count once
  assign spChange = sampleTick && (sp_q != spSeen_q);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      spSeen_q <= PAPT_ZERO;
    end else if (sampleTick) begin
      spSeen_q <= sp_q;
    end
  end

  logic signed [17:0] dev;
  logic signed [17:0] absDev;
  assign dev = 18'(pv_q) - 18'(sp_q);
  assign absDev = (dev < 0) ? -dev : dev;

  // ------------------------------------------------------------
  // per-alarm evaluation
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_ALARM; g++) begin : gAlm
      logic cond_q;
      logic cond_d;
      logic stby_q;
      logic stby_d;
      logic alm_d;
      logic signed [17:0] v;
      logic signed [17:0] h;
      logic signed [17:0] pv;
      logic latch;
      logic stbyEn;
      logic ack;
      logic route;
      papt_mode_t mode;
      // 18 bits: value plus hysteresis must not wrap at the 16-bit ends
      assign v = 18'(almVal_q[g]);
      assign h = 18'(almHys_q[g]);
      assign pv = 18'(pv_q);
      assign latch = almCfg_q[g][PAPT_CFG_LATCH_BIT];
      assign stbyEn = almCfg_q[g][PAPT_CFG_STBY_BIT];
      assign route = almCfg_q[g][PAPT_CFG_ROUTE_BIT];
      assign mode = papt_mode_t'(almCfg_q[g][PAPT_CFG_MODE_LSB +: 3]);
      assign ack = ack_q[g];

      // trip test alone when idle, widened by hysteresis once active
      always_comb begin
        case (mode)
          PAPT_ABS_LOW:
            cond_d = cond_q ? (pv <= v + h) : (pv < v);
          PAPT_ABS_HIGH:
            cond_d = cond_q ? (pv >= v - h) : (pv > v);
          PAPT_DEV_LOW:
            cond_d = cond_q ? (dev <= -v + h) : (dev <= -v);
          PAPT_DEV_HIGH:
            cond_d = cond_q ? (dev >= v - h) : (dev >= v);
          PAPT_IN_BAND:
            cond_d = cond_q ? (absDev <= v + h) : (absDev <= v);
          PAPT_OUT_BAND:
            cond_d = cond_q ? (absDev >= v - h) : (absDev >= v);
          default:
            cond_d = 1'b0;
        endcase
      end

      always_comb begin
        stby_d = stby_q;
        alm_d = 1'b0;
        if (!stbyEn) begin
          stby_d = 1'b0;
        end else if (spChange) begin
          stby_d = 1'b1;
        end else if (!cond_d) begin
          stby_d = 1'b0;
        end else if (latch && ack) begin
          stby_d = 1'b1;
        end
        if (!latch) begin
          alm_d = cond_d && !ack && !stby_d;
        end else if (ack) begin
          // standby variant disabled; plain variant just tracks
          alm_d = stbyEn ? 1'b0 : cond_d;
        end else if (stby_d) begin
          alm_d = 1'b0;
        end else begin
          alm_d = alm_q[g] || cond_d;
        end
      end

      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          cond_q <= 1'b0;
          stby_q <= 1'b1; // power-up suppression
          alm_q[g] <= 1'b0;
          alarmOut_q[g] <= 1'b0;
        end else if (sampleTick) begin
          cond_q <= cond_d;
          stby_q <= stby_d;
          alm_q[g] <= alm_d;
          alarmOut_q[g] <= alm_d && route;
        end
      end
    end
  endgenerate
  assign alarmOut = alarmOut_q;
endmodule : papt_core

// ==== hw/papt_pkg.sv ====
// Function
// - add the output offset to the computed power before splitting it
// - signed deadband: positive leaves a gap, negative gives overlap
// - heat demand scaled by heat gain; 100% equals proportional gain
// - cool demand scaled by cool gain; 100% equals proportional gain
// - heat power clamped to heat low/high limits, range beyond 100%
// - cool power clamped to cool low/high limits, same wide range
// - four independent alarms, status readable, optionally routed to pins
// - absolute low: on below value, off above value plus hysteresis
// - absolute high: on above value, off below value minus hysteresis
// - deviation low: on when below setpoint by at least value
// - deviation high: on when above setpoint by at least value
// - in band: on while distance to setpoint does not exceed value
// - out of band: on when distance to setpoint reaches value
// - hysteresis only widens the clearing side, never delays tripping
// - non-latching alarm follows condition; acknowledge bit disables it
// - latching alarm holds until acknowledged after condition cleared
// - latching without standby tracks condition while acknowledge held
// - standby suppresses alarm after reset or setpoint change until clear
// - latching standby: acknowledge kills alarm, stays off if persisting
// - latching standby: alarm never asserts while acknowledge held
package papt_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] PAPT_PV_OFF = 8'h00;
  localparam logic [7:0] PAPT_SP_OFF = 8'h04;
  localparam logic [7:0] PAPT_PWR_OFF = 8'h08;
  localparam logic [7:0] PAPT_OFFS_OFF = 8'h0C;
  localparam logic [7:0] PAPT_DBND_OFF = 8'h10;
  localparam logic [7:0] PAPT_HGAIN_OFF = 8'h14;
  localparam logic [7:0] PAPT_CGAIN_OFF = 8'h18;
  localparam logic [7:0] PAPT_HLO_OFF = 8'h1C;
  localparam logic [7:0] PAPT_HHI_OFF = 8'h20;
  localparam logic [7:0] PAPT_CLO_OFF = 8'h24;
  localparam logic [7:0] PAPT_CHI_OFF = 8'h28;
  localparam logic [7:0] PAPT_HEAT_OFF = 8'h2C;
  localparam logic [7:0] PAPT_COOL_OFF = 8'h30;
  localparam logic [7:0] PAPT_ASTAT_OFF = 8'h34;
  localparam logic [7:0] PAPT_ACK_OFF = 8'h38;
  // alarm n: base + n * stride; cfg, value, hysteresis words
  localparam logic [7:0] PAPT_ALM_BASE = 8'h40;
  localparam logic [7:0] PAPT_ALM_STRIDE = 8'h10;
  localparam logic [7:0] PAPT_ALM_CFG = 8'h00;
  localparam logic [7:0] PAPT_ALM_VAL = 8'h04;
  localparam logic [7:0] PAPT_ALM_HYS = 8'h08;
  // ------------------------------------------------------------
  // alarm config fields
  // ------------------------------------------------------------
  localparam int PAPT_CFG_MODE_LSB = 0;
  localparam int PAPT_CFG_LATCH_BIT = 4;
  localparam int PAPT_CFG_STBY_BIT = 5;
  localparam int PAPT_CFG_ROUTE_BIT = 6;
  typedef enum logic [2:0] {
    PAPT_ABS_LOW = 3'h0,
    PAPT_ABS_HIGH = 3'h1,
    PAPT_DEV_LOW = 3'h2,
    PAPT_DEV_HIGH = 3'h3,
    PAPT_IN_BAND = 3'h4,
    PAPT_OUT_BAND = 3'h5
  } papt_mode_t;
  // ------------------------------------------------------------
  // scaling and reset values (power in 0.01 %)
  // ------------------------------------------------------------
  localparam logic signed [15:0] PAPT_GAIN_UNITY = 16'sh2710;
  localparam logic signed [15:0] PAPT_LIM_MAX = 16'sh7FFF;
  localparam logic signed [15:0] PAPT_LIM_MIN = -16'sh7FFF;
  localparam logic signed [15:0] PAPT_ZERO = 16'sh0000;
endpackage : papt_pkg

// ==== sim/papt_assertions.sv ====
`timescale 1ns/1ps
module papt_checker
  import papt_pkg::*;
#(
  parameter int NUM_ALARM = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // sample and apb
  input wire logic sampleTick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // demands and alarm pins
  input wire logic signed [15:0] heatPower,
  input wire logic signed [15:0] coolPower,
  input wire logic [NUM_ALARM-1:0] alarmOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // shadow of the few registers the properties need
  // ------------------------------------------------------------
  logic signed [15:0] hLo_q;
  logic signed [15:0] hHi_q;
  logic ack_q;
  logic [6:4] cfg_q;
  wire wrEn = psel & penable & pwrite & pready;
  // ack mutes the pin unless latching without standby
  wire ackMute = ack_q & ~(cfg_q[4] & ~cfg_q[5]);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hLo_q <= PAPT_ZERO;
      hHi_q <= PAPT_LIM_MAX;
      ack_q <= 1'b0;
      cfg_q <= 3'h0;
    end else if (wrEn) begin
      case (paddr)
        PAPT_HLO_OFF: hLo_q <= pwdata[15:0];
        PAPT_HHI_OFF: hHi_q <= pwdata[15:0];
        PAPT_ACK_OFF: ack_q <= pwdata[0];
        PAPT_ALM_BASE: cfg_q <= pwdata[6:4];
        default: ;
      endcase
    end
  end
  property clampOk;
    sampleTick && hLo_q <= hHi_q |=>
      heatPower >= $past(hLo_q) && heatPower <= $past(hHi_q);
  endproperty
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  heat_hold_a: assert property (!sampleTick |=> $stable(heatPower))
    else $error("heat power moved without a sample");
  cool_hold_a: assert property (!sampleTick |=> $stable(coolPower))
    else $error("cool power moved without a sample");
  alarm_hold_a: assert property (!sampleTick |=> $stable(alarmOut))
    else $error("alarm pins moved without a sample");
  heat_clamp_a: assert property (clampOk)
    else $error("heat power outside its limits");
  ack_quiet_a: assert property (sampleTick && ackMute |=> !alarmOut[0])
    else $error("alarm raised while acknowledge held");
  route_off_a: assert property (sampleTick && !cfg_q[6] |=> !alarmOut[0])
    else $error("unrouted alarm drove its pin");
  bad_addr_err_a: assert property (
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  err_read_zero_a: assert property (
    psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  cover property (sampleTick ##1 heatPower != 0 && coolPower != 0);
  cover property (sampleTick ##1 $rose(alarmOut[0]));
  cover property (psel && penable && pslverr);
endmodule : papt_checker

bind papt_core papt_checker #(.NUM_ALARM(NUM_ALARM)) papt_checker_i (
  .clk(clk), .sys_rst(sys_rst), .sampleTick(sampleTick), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .heatPower(heatPower), .coolPower(coolPower), .alarmOut(alarmOut));

// ==== sim/papt_core_bench.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module papt_core_bench;
  import papt_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sampleTick = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic signed [15:0] heatPower;
  logic signed [15:0] coolPower;
  logic [3:0] alarmOut;
  int err_total = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'hBD6F215F;
  int rv[11];
  papt_core #(.NUM_ALARM(4)) papt_core_i (.clk(clk), .sys_rst(sys_rst),
    .sampleTick(sampleTick), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .heatPower(heatPower),
    .coolPower(coolPower), .alarmOut(alarmOut));
  always #2 clk = ~clk;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int rs(int span);
    return int'(rnd() % 32'(2 * span + 1)) - span;
  endfunction : rs
  // rv is indexed by byte offset / 4
  function automatic int xfer(bit cool);
    int p, h, r, lo, hi;
    p = rv[2] + rv[3];
    h = rv[4] >>> 1;
    if (!cool) begin
      r = (p > h) ? (p - h) * rv[5] / int'(PAPT_GAIN_UNITY) : 0;
      lo = rv[7];
      hi = rv[8];
    end else begin
      r = (p < -h) ? (-h - p) * rv[6] / int'(PAPT_GAIN_UNITY) : 0;
      lo = rv[9];
      hi = rv[10];
    end
    if (r < lo) r = lo;
    if (r > hi) r = hi;
    return r;
  endfunction : xfer
  // act selects the widened clearing side
  function automatic bit acond(int m, int pv, int sp, int v, int hy, bit act);
    int d, a;
    d = pv - sp;
    a = (d < 0) ? -d : d;
    hy = act ? -hy : 0;
    case (m)
      0: return act ? pv <= v - hy : pv < v;
      1: return act ? pv >= v + hy : pv > v;
      2: return d <= -v - hy;
      3: return d >= v + hy;
      4: return a <= v - hy;
      5: return a >= v + hy;
      default: return 1'b0;
    endcase
  endfunction : acond
  task automatic apb(bit w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(logic [7:0] a, int d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, 32'(d), q, e);
  endtask : wr
  task automatic tick();
    @(posedge clk);
    sampleTick <= 1'b1;
    @(posedge clk);
    sampleTick <= 1'b0;
    #1;
  endtask : tick
  task automatic astep(bit ack, int pv, bit ex);
    wr(PAPT_ACK_OFF, ack);
    wr(PAPT_PV_OFF, pv);
    tick();
    `CHK(alarmOut[0], ex)
  endtask : astep
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    err_total++;
    final_report();
  end
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic e;
    logic [3:0] st, ro;
    int am[4], av[4], ah[4];
    int pv, sp;
    logic [7:0] b;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, PAPT_HGAIN_OFF, 0, q, e);
    `CHK(q, 32'h0000_2710)
    apb(1'b0, PAPT_CHI_OFF, 0, q, e);
    `CHK(q, 32'h0000_7FFF)
    apb(1'b0, 8'h3D, 0, q, e);
    `CHK(e, 1'b1)
    rv = '{default: 0};
    rv[5] = 10000;
    rv[6] = 10000;
    rv[8] = 32767;
    rv[10] = 32767;
    // first two passes: overlap at zero power, then a gap
    for (int i = 0; i < 40; i++) begin
      if (i == 0) rv[4] = -2000;
      else if (i == 1) begin
        rv[2] = 500;
        rv[4] = 2000;
      end else begin
        for (int r = 2; r < 7; r++) rv[r] = rs(10000);
        rv[5] += 10000;
        rv[6] += 10000;
        rv[7] = rs(15000);
        rv[8] = rv[7] + int'(rnd() % 17000);
        rv[9] = rs(15000);
        rv[10] = rv[9] + int'(rnd() % 17000);
      end
      for (int r = 2; r < 11; r++) wr(8'(4 * r), rv[r]);
      tick();
      `CHK(heatPower, 16'(xfer(0)))
      `CHK(coolPower, 16'(xfer(1)))
      apb(1'b0, PAPT_COOL_OFF, 0, q, e);
      `CHK(q, 32'(xfer(1)))
    end
    st = 4'h0;
    for (int k = 0; k < 4; k++) begin
      for (int n = 0; n < 4; n++) begin
        b = PAPT_ALM_BASE + 8'(16 * n);
        am[n] = int'(rnd() % 6);
        av[n] = rs(300);
        ah[n] = int'(rnd() % 50);
        ro[n] = 1'(rnd() % 2);
        wr(b, am[n] | int'(ro[n]) << PAPT_CFG_ROUTE_BIT);
        wr(b + PAPT_ALM_VAL, av[n]);
        wr(b + PAPT_ALM_HYS, ah[n]);
      end
      for (int t = 0; t < 20; t++) begin
        pv = rs(500);
        sp = rs(300);
        wr(PAPT_PV_OFF, pv);
        wr(PAPT_SP_OFF, sp);
        tick();
        for (int n = 0; n < 4; n++) begin
          st[n] = acond(am[n], pv, sp, av[n], ah[n], st[n]);
          `CHK(alarmOut[n], st[n] & ro[n])
        end
        apb(1'b0, PAPT_ASTAT_OFF, 0, q, e);
        `CHK(q, {28'h0, st})
      end
    end
    // alarm 0 absolute high at 100, no hysteresis
    wr(PAPT_ALM_BASE + PAPT_ALM_VAL, 100);
    wr(PAPT_ALM_BASE + PAPT_ALM_HYS, 0);
    wr(PAPT_ALM_BASE, 32'h41);
    astep(1'b0, 50, 1'b0);
    astep(1'b0, 200, 1'b1);
    astep(1'b1, 200, 1'b0);
    astep(1'b0, 200, 1'b1);
    astep(1'b0, 50, 1'b0);
    wr(PAPT_ALM_BASE, 32'h51);
    astep(1'b0, 200, 1'b1);
    astep(1'b0, 50, 1'b1);
    astep(1'b1, 50, 1'b0);
    astep(1'b1, 200, 1'b1);
    astep(1'b1, 50, 1'b0);
    astep(1'b0, 50, 1'b0);
    wr(PAPT_ALM_BASE, 32'h71);
    wr(PAPT_SP_OFF, 777);
    astep(1'b0, 200, 1'b0);
    astep(1'b0, 50, 1'b0);
    astep(1'b0, 200, 1'b1);
    astep(1'b1, 200, 1'b0);
    astep(1'b0, 200, 1'b0);
    astep(1'b0, 50, 1'b0);
    astep(1'b0, 200, 1'b1);
    astep(1'b1, 50, 1'b0);
    astep(1'b1, 200, 1'b0);
    final_report();
  end
endmodule : papt_core_bench
